// ==== stoa_alu.sv ====
// Summary of operation
// (RQ1) Unsigned add: 33-bit sum, low word out, flag on carry out.
// (RQ2) Unsigned subtract: first minus second, flag when second exceeds first.
// (RQ3) Signed add: flag on signed overflow of same-signed sources.
// (RQ4) Signed subtract: flag when signs differ and result sign leaves first's.
// (RQ5) Add with carry: sources plus incoming flag, flag on carry out.
// (RQ6) Subtract with borrow: flag when second plus incoming flag exceeds first.
// (RQ7) Absolute difference: magnitude, flag when nonzero; 0x80000000 stays.
// (RQ8) Logical shifts: five or six amount bits, zero fill, flag when nonzero.
// (RQ9) Arithmetic right shifts: sign fill, same amounts, flag when nonzero.
// (RQ10) Shift-then-add by one to four, flag on carry out of 32 bits.
// (RQ11) Minimum: flag when first is less, pick first if flagged.
// (RQ12) Maximum: flag when first is greater, pick first if flagged.
// (RQ13) A literal word may replace either source operand.
// (RQ14) Destination and flag commit together in the same cycle.
`timescale 1ns/100ps
module stoa_alu
(
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Issue.
   input wire logic i_valid,
   input wire logic [4:0] i_op,
   input wire logic [63:0] i_first_source,
   input wire logic [63:0] i_second_source,
   input wire logic [31:0] i_literal,
   input wire logic i_first_is_literal,
   input wire logic i_second_is_literal,
   input wire logic i_scalar_condition_flag,
   // Result.
   output logic o_valid,
   output logic [63:0] o_destination_value,
   output logic o_scalar_condition_flag
);
   // The literal replaces the whole source, zero-extended; a 64-bit shift with a literal sees zero above.
   wire logic [63:0] src_a = i_first_is_literal ? {stoa_pkg::ZERO32, i_literal}
                                               : i_first_source; // [RQ13]
   wire logic [63:0] src_b = i_second_is_literal ? {stoa_pkg::ZERO32, i_literal}
                                                : i_second_source; // [RQ13]
   wire logic [31:0] a = src_a[31:0];
   wire logic [31:0] b = src_b[31:0];
   wire logic cin = i_scalar_condition_flag;
   wire logic sa = a[stoa_pkg::SIGN_BIT];
   wire logic sb = b[stoa_pkg::SIGN_BIT];

   wire logic [32:0] add_sum = {1'h0, a} + {1'h0, b}; // [RQ1]
   wire logic [32:0] addc_sum = {1'h0, a} + {1'h0, b} + {32'h0, cin}; // [RQ5]
   wire logic [31:0] sub_diff = a - b; // [RQ2]
   wire logic [31:0] subb_diff = a - b - {31'h0, cin}; // [RQ6]
   wire logic [32:0] subb_need = {1'h0, b} + {32'h0, cin}; // [RQ6]
   wire logic sadd_ovf = (sa == sb) && (sa != add_sum[stoa_pkg::SIGN_BIT]); // [RQ3]
   wire logic ssub_ovf = (sa != sb) && (sa != sub_diff[stoa_pkg::SIGN_BIT]); // [RQ4]
   // Negating 0x80000000 wraps back onto itself, so it leaves unchanged.
   wire logic [31:0] abs_diff = sub_diff[stoa_pkg::SIGN_BIT] ? (~sub_diff + 32'h1)
                                                             : sub_diff; // [RQ7]

   wire logic [4:0] amt32 = b[stoa_pkg::SH32_W-1:0]; // [RQ8]
   wire logic [5:0] amt64 = b[stoa_pkg::SH64_W-1:0]; // [RQ8]
   wire logic [31:0] shl32 = a << amt32;
   wire logic [31:0] shr32 = a >> amt32;
   wire logic [63:0] shl64 = src_a << amt64;
   wire logic [63:0] shr64 = src_a >> amt64;
   wire logic [31:0] asr32 = $signed(a) >>> amt32; // [RQ9]
   wire logic [63:0] asr64 = $signed(src_a) >>> amt64; // [RQ9]

   // One adder per shift distance; the largest sum needs 37 bits.
   wire logic [36:0] shadd [1:stoa_pkg::SHADD_MAX];
   genvar gi;
   generate
      for (gi = 1; gi <= stoa_pkg::SHADD_MAX; gi++)
      begin : g_shadd
         assign shadd[gi] = ({5'h0, a} << gi) + {5'h0, b}; // [RQ10]
      end
   endgenerate

   wire logic slt = $signed(a) < $signed(b);
   wire logic ult = a < b;
   wire logic sgt = $signed(a) > $signed(b);
   wire logic ugt = a > b;

   logic [63:0] res;
   logic flag;
   logic known;
   always_comb
   begin
      res = stoa_pkg::ZERO64;
      flag = stoa_pkg::ZERO1;
      known = 1'h1;
      unique case (i_op)
         stoa_pkg::OP_UADD:
         begin
            res = {stoa_pkg::ZERO32, add_sum[31:0]};
            flag = add_sum[stoa_pkg::SUM_W-1]; // [RQ1]
         end
         stoa_pkg::OP_USUB:
         begin
            res = {stoa_pkg::ZERO32, sub_diff};
            flag = b > a; // [RQ2]
         end
         stoa_pkg::OP_SADD:
         begin
            res = {stoa_pkg::ZERO32, add_sum[31:0]};
            flag = sadd_ovf; // [RQ3]
         end
         stoa_pkg::OP_SSUB:
         begin
            res = {stoa_pkg::ZERO32, sub_diff};
            flag = ssub_ovf; // [RQ4]
         end
         stoa_pkg::OP_ADDC:
         begin
            res = {stoa_pkg::ZERO32, addc_sum[31:0]};
            flag = addc_sum[stoa_pkg::SUM_W-1]; // [RQ5]
         end
         stoa_pkg::OP_SUBB:
         begin
            res = {stoa_pkg::ZERO32, subb_diff};
            flag = subb_need > {1'h0, a}; // [RQ6]
         end
         stoa_pkg::OP_ABSD:
         begin
            res = {stoa_pkg::ZERO32, abs_diff};
            flag = abs_diff != stoa_pkg::ZERO32; // [RQ7]
         end
         stoa_pkg::OP_SHL32:
         begin
            res = {stoa_pkg::ZERO32, shl32};
            flag = shl32 != stoa_pkg::ZERO32; // [RQ8]
         end
         stoa_pkg::OP_SHL64:
         begin
            res = shl64;
            flag = shl64 != stoa_pkg::ZERO64; // [RQ8]
         end
         stoa_pkg::OP_SHR32:
         begin
            res = {stoa_pkg::ZERO32, shr32};
            flag = shr32 != stoa_pkg::ZERO32; // [RQ8]
         end
         stoa_pkg::OP_SHR64:
         begin
            res = shr64;
            flag = shr64 != stoa_pkg::ZERO64; // [RQ8]
         end
         stoa_pkg::OP_ASR32:
         begin
            res = {stoa_pkg::ZERO32, asr32};
            flag = asr32 != stoa_pkg::ZERO32; // [RQ9]
         end
         stoa_pkg::OP_ASR64:
         begin
            res = asr64;
            flag = asr64 != stoa_pkg::ZERO64; // [RQ9]
         end
         stoa_pkg::OP_SH1ADD, stoa_pkg::OP_SH2ADD, stoa_pkg::OP_SH3ADD, stoa_pkg::OP_SH4ADD:
         begin
            res = {stoa_pkg::ZERO32, shadd[i_op - stoa_pkg::OP_SH1ADD + 1][31:0]};
            flag = |shadd[i_op - stoa_pkg::OP_SH1ADD + 1][36:32]; // [RQ10]
         end
         stoa_pkg::OP_SMIN:
         begin
            flag = slt; // [RQ11]
            res = {stoa_pkg::ZERO32, slt ? a : b}; // [RQ11]
         end
         stoa_pkg::OP_UMIN:
         begin
            flag = ult; // [RQ11]
            res = {stoa_pkg::ZERO32, ult ? a : b}; // [RQ11]
         end
         stoa_pkg::OP_SMAX:
         begin
            flag = sgt; // [RQ12]
            res = {stoa_pkg::ZERO32, sgt ? a : b}; // [RQ12]
         end
         stoa_pkg::OP_UMAX:
         begin
            flag = ugt; // [RQ12]
            res = {stoa_pkg::ZERO32, ugt ? a : b}; // [RQ12]
         end
         default:
         begin
            // Unknown codes are refused and commit nothing, so a stray issue cannot corrupt a chain.
            known = 1'h0;
            flag = cin;
         end
      endcase
   end

   logic valid_ff;
   logic [63:0] dest_ff;
   logic flag_ff;
   wire logic take = i_ce & i_valid;
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         valid_ff <= 1'h0;
         dest_ff <= stoa_pkg::ZERO64;
         flag_ff <= stoa_pkg::ZERO1;
      end
      else if (i_ce)
      begin
         valid_ff <= i_valid & known;
         if (take && known)
         begin
            dest_ff <= res; // [RQ14]
            flag_ff <= flag; // [RQ14]
         end
      end
   end
   assign o_valid = valid_ff;
   assign o_destination_value = dest_ff;
   assign o_scalar_condition_flag = flag_ff;

   property p_uadd;
      @(posedge i_mclk) disable iff (i_rst)
      (take && i_op == stoa_pkg::OP_UADD) |=>
         o_scalar_condition_flag == $past(add_sum[32]) && o_valid;
   endproperty
   a_uadd: assert property (p_uadd) else $error("add carry wrong"); // [RQ1]

   property p_usub;
      @(posedge i_mclk) disable iff (i_rst)
      (take && i_op == stoa_pkg::OP_USUB) |=> o_scalar_condition_flag == ($past(b) > $past(a));
   endproperty
   a_usub: assert property (p_usub) else $error("sub borrow wrong"); // [RQ2]

   property p_sadd;
      @(posedge i_mclk) disable iff (i_rst)
      (take && i_op == stoa_pkg::OP_SADD && sa != sb) |=> !o_scalar_condition_flag;
   endproperty
   a_sadd: assert property (p_sadd) else $error("signed add overflow on mixed signs"); // [RQ3]

   property p_ssub;
      @(posedge i_mclk) disable iff (i_rst)
      (take && i_op == stoa_pkg::OP_SSUB && sa == sb) |=> !o_scalar_condition_flag;
   endproperty
   a_ssub: assert property (p_ssub) else $error("signed sub overflow on equal signs"); // [RQ4]

   property p_addc;
      @(posedge i_mclk) disable iff (i_rst)
      (take && i_op == stoa_pkg::OP_ADDC) |=>
         o_destination_value[31:0] == $past(a) + $past(b) + {31'h0, $past(cin)};
   endproperty
   a_addc: assert property (p_addc) else $error("add with carry sum wrong"); // [RQ5]

   property p_subb;
      @(posedge i_mclk) disable iff (i_rst)
      (take && i_op == stoa_pkg::OP_SUBB && a == b) |=> o_scalar_condition_flag == $past(cin);
   endproperty
   a_subb: assert property (p_subb) else $error("borrow on equal operands wrong"); // [RQ6]

   property p_absd;
      @(posedge i_mclk) disable iff (i_rst)
      (take && i_op == stoa_pkg::OP_ABSD) |=>
         o_scalar_condition_flag == ($past(a) != $past(b));
   endproperty
   a_absd: assert property (p_absd) else $error("absolute difference flag wrong"); // [RQ7]

   property p_shift;
      @(posedge i_mclk) disable iff (i_rst)
      (take && (i_op == stoa_pkg::OP_SHL64 || i_op == stoa_pkg::OP_ASR64)) |=>
         o_scalar_condition_flag == (o_destination_value != stoa_pkg::ZERO64);
   endproperty
   a_shift: assert property (p_shift) else $error("shift flag disagrees with result"); // [RQ8]

   property p_minmax;
      @(posedge i_mclk) disable iff (i_rst)
      (take && (i_op == stoa_pkg::OP_UMIN || i_op == stoa_pkg::OP_UMAX)) |=>
         o_destination_value[31:0] == (o_scalar_condition_flag ? $past(a) : $past(b));
   endproperty
   a_minmax: assert property (p_minmax) else $error("min or max pick wrong"); // [RQ11]

   property p_hold;
      @(posedge i_mclk) disable iff (i_rst)
      !i_ce |=> $stable(o_scalar_condition_flag) && $stable(o_destination_value);
   endproperty
   a_hold: assert property (p_hold) else $error("result moved while frozen"); // [RQ14]

   property p_refuse;
      @(posedge i_mclk) disable iff (i_rst)
      (take && !known) |=>
         !o_valid && $stable(o_scalar_condition_flag) && $stable(o_destination_value);
   endproperty
   a_refuse: assert property (p_refuse) else $error("refused opcode changed the result"); // [RQ14]
endmodule

// ==== stoa_pkg.sv ====
package stoa_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned WIDE_W = 64;
   localparam int unsigned SUM_W = 33;
   localparam int unsigned OP_W = 5;
   localparam int unsigned SIGN_BIT = 31;
   localparam int unsigned SH32_W = 5;
   localparam int unsigned SH64_W = 6;
   localparam int unsigned SHADD_MAX = 4;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   localparam logic [63:0] ZERO64 = 64'h0000_0000_0000_0000;
   localparam logic ZERO1 = 1'h0;

   typedef enum logic [4:0] {
      OP_UADD = 5'h00,
      OP_USUB = 5'h01,
      OP_SADD = 5'h02,
      OP_SSUB = 5'h03,
      OP_ADDC = 5'h04,
      OP_SUBB = 5'h05,
      OP_ABSD = 5'h06,
      OP_SHL32 = 5'h07,
      OP_SHL64 = 5'h08,
      OP_SHR32 = 5'h09,
      OP_SHR64 = 5'h0a,
      OP_ASR32 = 5'h0b,
      OP_ASR64 = 5'h0c,
      OP_SH1ADD = 5'h0d,
      OP_SH2ADD = 5'h0e,
      OP_SH3ADD = 5'h0f,
      OP_SH4ADD = 5'h10,
      OP_SMIN = 5'h11,
      OP_UMIN = 5'h12,
      OP_SMAX = 5'h13,
      OP_UMAX = 5'h14
   } stoa_op_t;
endpackage

// ==== stoa_seq_model.sv ====
`timescale 1ns/100ps
// Sequencer side of the flag path. The ALU does not feed its flag back on its own.
module stoa_seq_model
(
   // Control.
   input wire logic i_route,
   // Flags.
   input wire logic i_bench_flag,
   input wire logic i_alu_flag,
   output logic o_flag
);
   // With i_route set, chained carries and borrows take the committed flag of the previous op; otherwise the bench flag.
   assign o_flag = i_route ? i_alu_flag : i_bench_flag;
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   logic mclk = 1'h0, rst = 1'h1, ce = 1'h1, v = 1'h0, fl = 1'h0, sl = 1'h0;
   logic cin = 1'h0, route = 1'h0, flag_in, o_valid, o_flag;
   logic [4:0] opr = 5'h00;
   logic [63:0] s0 = 64'h0, s1 = 64'h0, o_value;
   logic [31:0] lit = 32'h0;
   int fails = 0, checks = 0;
   always #50 mclk = ~mclk;
   stoa_seq_model seq_u (.i_route(route), .i_bench_flag(cin), .i_alu_flag(o_flag),
      .o_flag(flag_in));
   stoa_alu dut_u (.i_mclk(mclk), .i_rst(rst), .i_ce(ce), .i_valid(v), .i_op(opr),
      .i_first_source(s0), .i_second_source(s1), .i_literal(lit),
      .i_first_is_literal(fl), .i_second_is_literal(sl),
      .i_scalar_condition_flag(flag_in), .o_valid(o_valid),
      .o_destination_value(o_value), .o_scalar_condition_flag(o_flag));

   function automatic logic [64:0] ref_op(input logic [4:0] op, input logic [63:0] a, b,
      input logic c);
      logic [31:0] x, y, r;
      logic [63:0] t;
      logic f, nz;
      x = a[31:0];
      y = b[31:0];
      t = 64'h0;
      f = 1'h0;
      nz = 1'h0;
      case (op)
         5'h00: begin t = {32'h0, x} + y; f = t[32]; end
         5'h01: begin t = x - y; f = y > x; end
         5'h02: begin t = x + y; f = (x[31] == y[31]) && (t[31] != x[31]); end
         5'h03: begin t = x - y; f = (x[31] != y[31]) && (t[31] != x[31]); end
         5'h04: begin t = {32'h0, x} + y + c; f = t[32]; end
         5'h05: begin t = x - y - c; f = ({32'h0, y} + c) > x; end
         5'h06: begin r = x - y; if (r[31]) r = -r; t = r; nz = 1'h1; end
         5'h07: begin t = x << b[4:0]; nz = 1'h1; end
         5'h08: begin t = a << b[5:0]; nz = 1'h1; end
         5'h09: begin t = x >> b[4:0]; nz = 1'h1; end
         5'h0a: begin t = a >> b[5:0]; nz = 1'h1; end
         5'h0b: begin t = $signed(x) >>> b[4:0]; nz = 1'h1; end
         5'h0c: begin t = $signed(a) >>> b[5:0]; nz = 1'h1; end
         5'h11: begin f = $signed(x) < $signed(y); t = f ? x : y; end
         5'h12: begin f = x < y; t = f ? x : y; end
         5'h13: begin f = $signed(x) > $signed(y); t = f ? x : y; end
         5'h14: begin f = x > y; t = f ? x : y; end
         default: begin t = ({32'h0, x} << (op - 5'h0c)) + y; f = t[63:32] != 32'h0; end
      endcase
      if (op != 5'h08 && op != 5'h0a && op != 5'h0c)
         t[63:32] = 32'h0;
      if (nz)
         f = t != 64'h0;
      return {f, t};
   endfunction

   task automatic run(input logic [4:0] op, input logic [63:0] a, b, input logic c);
      @(posedge mclk);
      v <= 1'h1;
      opr <= op;
      s0 <= a;
      s1 <= b;
      cin <= c;
      @(posedge mclk);
      v <= 1'h0;
      #1;
      `CHK(o_valid, 1'h1)
      `CHK({o_flag, o_value}, ref_op(op, fl ? {32'h0, lit} : a, sl ? {32'h0, lit} : b, c))
   endtask

   task automatic t_arith();
      run(stoa_pkg::OP_UADD, 64'hffffffff, 64'h1, 1'h0);
      run(stoa_pkg::OP_UADD, 64'hfffffffe, 64'h1, 1'h0);
      run(stoa_pkg::OP_USUB, 64'h3, 64'h4, 1'h0);
      run(stoa_pkg::OP_USUB, 64'h4, 64'h4, 1'h0);
      run(stoa_pkg::OP_SADD, 64'h7fffffff, 64'h1, 1'h0);
      run(stoa_pkg::OP_SADD, 64'h80000000, 64'hffffffff, 1'h0);
      run(stoa_pkg::OP_SADD, 64'hffffffff, 64'h1, 1'h0);
      run(stoa_pkg::OP_SSUB, 64'h80000000, 64'h1, 1'h0);
      run(stoa_pkg::OP_SSUB, 64'h7fffffff, 64'hffffffff, 1'h0);
      run(stoa_pkg::OP_SSUB, 64'h0, 64'h1, 1'h0);
      run(stoa_pkg::OP_ABSD, 64'h80000000, 64'h0, 1'h0);
      run(stoa_pkg::OP_ABSD, 64'h2, 64'h5, 1'h0);
      run(stoa_pkg::OP_ABSD, 64'h80000000, 64'hfffffffe, 1'h0);
      run(stoa_pkg::OP_ABSD, 64'h7, 64'h7, 1'h0);
      run(stoa_pkg::OP_SUBB, 64'h0, 64'hffffffff, 1'h1);
      run(stoa_pkg::OP_SUBB, 64'h9, 64'h9, 1'h1);
      $display("arith done");
   endtask

   task automatic t_chain();
      run(stoa_pkg::OP_UADD, 64'hffffffff, 64'h1, 1'h0);
      route <= 1'h1;
      run(stoa_pkg::OP_ADDC, 64'hffffffff, 64'h0, 1'h1);
      run(stoa_pkg::OP_ADDC, 64'h1, 64'h2, 1'h1);
      route <= 1'h0;
      run(stoa_pkg::OP_USUB, 64'h0, 64'h1, 1'h0);
      route <= 1'h1;
      run(stoa_pkg::OP_SUBB, 64'h5, 64'h2, 1'h1);
      route <= 1'h0;
      $display("chain done");
   endtask

   task automatic t_shift();
      for (int i = 7; i <= 12; i++)
         run(5'(i), 64'h80000000f0000001, 64'hffffffe5, 1'h0);
      run(stoa_pkg::OP_SHL32, 64'h80000000, 64'h21, 1'h0);
      run(stoa_pkg::OP_ASR32, 64'h7ffffff0, 64'h3f, 1'h0);
      for (int n = 0; n < 4; n++)
         run(5'(13 + n), 64'h40000001, 64'hffffffff, 1'h0);
      run(stoa_pkg::OP_SH1ADD, 64'h1, 64'h2, 1'h0);
      $display("shift done");
   endtask

   task automatic t_minmax();
      for (int i = 17; i <= 20; i++)
      begin
         run(5'(i), 64'hffffffff, 64'h1, 1'h0);
         run(5'(i), 64'h1, 64'hffffffff, 1'h0);
         run(5'(i), 64'h5, 64'h5, 1'h0);
      end
      $display("minmax done");
   endtask

   task automatic t_literal();
      @(posedge mclk);
      lit <= 32'h80000001;
      fl <= 1'h1;
      run(stoa_pkg::OP_UADD, 64'h123, 64'h7fffffff, 1'h0);
      @(posedge mclk);
      fl <= 1'h0;
      sl <= 1'h1;
      run(stoa_pkg::OP_USUB, 64'h5, 64'h0, 1'h0);
      @(posedge mclk);
      sl <= 1'h0;
      $display("literal done");
   endtask

   task automatic t_b2b_refuse();
      @(posedge mclk);
      v <= 1'h1;
      opr <= stoa_pkg::OP_UADD;
      s0 <= 64'hffffffff;
      s1 <= 64'h1;
      @(posedge mclk);
      opr <= stoa_pkg::OP_UMIN;
      s0 <= 64'h7;
      s1 <= 64'h3;
      #1;
      `CHK({o_valid, o_flag, o_value}, {2'h3, 64'h0})
      @(posedge mclk);
      opr <= 5'h1f;
      cin <= 1'h1;
      #1;
      `CHK({o_valid, o_flag, o_value}, {2'h2, 64'h3})
      @(posedge mclk);
      ce <= 1'h0;
      opr <= stoa_pkg::OP_UADD;
      #1;
      `CHK({o_valid, o_flag, o_value}, {2'h0, 64'h3})
      @(posedge mclk);
      #1;
      `CHK({o_valid, o_flag, o_value}, {2'h0, 64'h3})
      @(posedge mclk);
      ce <= 1'h1;
      v <= 1'h0;
      $display("b2b refuse done");
   endtask

   task automatic report_and_stop();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (5) @(posedge mclk);
      rst <= 1'h0;
      #1;
      `CHK({o_valid, o_flag, o_value}, 66'h0)
      t_arith();
      t_chain();
      t_shift();
      t_minmax();
      t_literal();
      t_b2b_refuse();
      report_and_stop();
   end

   initial
   begin
      #400000;
      fails++;
      report_and_stop();
   end
endmodule
